// *** src/sbva_pkg.sv ***
// shared constants and types of the byte vector datapath
package sbva_pkg;

  // ------------------------------------------------------------------
  // geometry
  // ------------------------------------------------------------------
  localparam int LANES = 16;
  localparam int LANE_W = 8;
  localparam int VEC_W = 128;
  localparam int VREGS = 32;
  localparam int VIDX_W = 5;
  localparam int ACC_W = 28;
  localparam int NCOND = 4;
  localparam int COND_W = 32;
  localparam int ZF_LSB = 16;
  localparam logic [2:0] FLAG_TARGET_NONE = 3'h7;

  // ------------------------------------------------------------------
  // opcodes
  // ------------------------------------------------------------------
  localparam logic [7:0] OP_SWZ = 8'h9b;
  localparam logic [7:0] OP_MOV = 8'ha2;
  localparam logic [7:0] OP_MOVI = 8'ha3;
  localparam logic [7:0] OP_MOVVC = 8'ha4;
  localparam logic [7:0] OP_CLIP_DEFAULT = 8'ha6;
  localparam int OPB_IMM = 5;
  localparam int OPB_UNS = 4;

  // ------------------------------------------------------------------
  // readout arithmetic
  // ------------------------------------------------------------------
  localparam logic signed [6:0] RD_BASE_INT = 7'sh10;
  localparam logic signed [6:0] RD_BASE_UFRAC = 7'sh08;
  localparam logic signed [6:0] RD_BASE_SFRAC = 7'sh09;
  localparam logic signed [6:0] RD_LO_OFFSET = 7'sh08;
  localparam logic signed [31:0] RD_UMAX = 32'sh0000ffff;
  localparam logic signed [31:0] RD_SMAX = 32'sh00007fff;
  localparam logic signed [31:0] RD_SMIN = -32'sh00008000;
  localparam logic signed [9:0] B_UMAX = 10'sh0ff;
  localparam logic signed [9:0] B_SMAX = 10'sh07f;
  localparam logic signed [9:0] B_SMIN = -10'sh080;

  // ------------------------------------------------------------------
  // apb register map
  // ------------------------------------------------------------------
  localparam logic [11:0] REG_CFG = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_COND0 = 12'h010;
  localparam logic [11:0] REG_COND3 = 12'h01c;
  localparam int CFG_TIE_BIT = 0;
  localparam logic CFG_TIE_RESET = 1'b0;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } sbva_state_e;

  typedef enum logic [2:0] {
    AOP_MIN = 3'b000,
    AOP_MAX = 3'b001,
    AOP_ABS = 3'b010,
    AOP_NEG = 3'b011,
    AOP_ADD = 3'b100,
    AOP_SUB = 3'b101,
    AOP_NONE = 3'b111
  } sbva_aop_e;

endpackage : sbva_pkg

// *** src/sbva_vreg_mem.sv ***
// vector register file with registered read ports
module sbva_vreg_mem
  import sbva_pkg::*;
#(
  parameter int DEPTH = VREGS,
  parameter int WIDTH = VEC_W,
  parameter int AW = VIDX_W,
  parameter int NRD = 4
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic [NRD*AW-1:0] rd_addr, // packed read addresses
  output logic [NRD*WIDTH-1:0] rd_data, // packed read data, registered
  input wire logic we, // write enable
  input wire logic [AW-1:0] wr_addr, // write address
  input wire logic [WIDTH-1:0] wr_data // write data
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [NRD-1:0][WIDTH-1:0] rd;
  } sbva_mem_s;

  sbva_mem_s q;
  sbva_mem_s next_q;

  always_comb begin
    next_q = q;
    for (int i = 0; i < NRD; i++) begin
      next_q.rd[i] = q.mem[rd_addr[i*AW +: AW]];
    end
    if (we) begin
      next_q.mem[wr_addr] = wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign rd_data = q.rd;

endmodule : sbva_vreg_mem

// *** src/sbva_readout_lane.sv ***
// accumulator rounding and readout for one lane
module sbva_readout_lane
  import sbva_pkg::*;
(
  input wire logic [ACC_W-1:0] acc_in, // accumulator lane
  input wire logic fractint, // 1 integer, 0 fraction
  input wire logic is_unsigned, // unsigned readout
  input wire logic [2:0] shift, // signed shift, subtracted from the right shift
  input wire logic hilo_lo, // 1 low byte, 0 high byte
  input wire logic rnd, // round to nearest
  input wire logic tie_down, // ties rounded down
  output logic [ACC_W-1:0] acc_out, // rounded accumulator lane
  output logic [LANE_W-1:0] byte_out // selected result byte
);

  logic signed [6:0] sh_ext;
  logic signed [6:0] shf;
  logic signed [6:0] rsh;
  logic signed [6:0] rsh_m1;
  logic signed [6:0] rd;
  logic signed [6:0] rd_neg;
  logic signed [28:0] sum;
  logic signed [31:0] val;
  logic signed [31:0] clipped;

  always_comb begin
    sh_ext = {{4{shift[2]}}, shift};
    shf = (fractint ? RD_BASE_INT : (is_unsigned ? RD_BASE_UFRAC : RD_BASE_SFRAC)) - sh_ext;
    rsh = hilo_lo ? shf - RD_LO_OFFSET : shf;
    rsh_m1 = rsh - 7'sh01;
    sum = {acc_in[ACC_W-1], acc_in};
    if (rnd) begin
      if (rsh > 7'sh00) begin
        sum = sum + (29'sh1 <<< rsh_m1[4:0]);
      end
      if (tie_down) begin
        sum = sum - 29'sh1;
      end
    end
    acc_out = sum[ACC_W-1:0];
    val = {{4{acc_out[ACC_W-1]}}, acc_out};
    rd = shf - RD_LO_OFFSET;
    rd_neg = -rd;
    if (rd >= 7'sh00) begin
      val = val >>> rd[4:0];
    end else begin
      val = val <<< rd_neg[4:0];
    end
    clipped = val;
    if (is_unsigned) begin
      if (val < 32'sh0) clipped = 32'sh0;
      if (val > RD_UMAX) clipped = RD_UMAX;
    end else begin
      if (val < RD_SMIN) clipped = RD_SMIN;
      if (val > RD_SMAX) clipped = RD_SMAX;
    end
    byte_out = hilo_lo ? clipped[7:0] : clipped[15:8];
  end

endmodule : sbva_readout_lane

// *** src/sbva_core.sv ***
// byte vector execution datapath with apb status and config
// What this block does
// - round-to-nearest adds half of the final shift, low byte shift reduced by 8
// - with downward ties, one is subtracted after the rounding correction
// - accumulator lanes are 28 bits and wrap, no saturation
// - readout shifts right by shift factor minus 8, negative shifts left
// - shifted value saturates to 16-bit unsigned or signed range
// - high selection returns bits 15:8, low selection returns bits 7:0
// - register move copies all lanes, clears sign flags, zero flags per lane
// - immediate move fills lanes, sign flag from bit 7, zero if immediate zero
// - condition move packs four flag registers into four-byte groups
// - swizzle picks lanes from sources one or two by selector bytes
// - opcode bit 0x20 picks immediate operand, bit 0x10 unsigned treatment
// - register forms decoded at 0x88-0x8d, unsigned at 0x9a, 0x9c, 0x9d
// - immediate forms decoded at the seven listed opcodes
// - unsigned results clip to byte range, sign flag marks overflow
// - signed sign flag is result sign, then clip to signed byte range
// - range clipping is signed, sign flag set when value clipped or equal
// - improper range swaps endpoints and sets the sign flag
// - four condition registers, sign flags low half, zero flags high half
// - flag target below 4 selects a register, larger values write nothing
// - shift factor is 16, 8 or 9 minus the immediate shift by mode
// - thirty-two vector registers of sixteen byte lanes
module sbva_core
  import sbva_pkg::*;
#(
  parameter logic [7:0] CLIP_OPCODE = OP_CLIP_DEFAULT
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic issue_valid, // instruction offered
  output logic issue_ready, // instruction accepted when high
  input wire logic issue_readout, // accumulator readout instead of opcode
  input wire logic [7:0] opcode, // decoded opcode
  input wire logic [VIDX_W-1:0] dest_index, // destination vector register
  input wire logic [VIDX_W-1:0] first_source_index, // source one
  input wire logic [VIDX_W-1:0] second_source_index, // source two
  input wire logic [VIDX_W-1:0] third_source_index, // source three
  input wire logic [7:0] byte_immediate, // immediate byte
  input wire logic [2:0] flag_target_index, // condition register to write
  input wire logic selector_nibble_order, // swizzle selector decode, 1 high
  input wire logic readout_int, // readout integer mode
  input wire logic readout_unsigned, // readout unsigned
  input wire logic [2:0] readout_shift, // readout signed shift
  input wire logic readout_lo, // readout low byte
  input wire logic readout_rnd, // readout round to nearest
  input wire logic acc_load_valid, // load accumulator while idle
  input wire logic [LANES*ACC_W-1:0] acc_load_data, // accumulator load value
  output logic [LANES*ACC_W-1:0] wide_accumulator, // accumulator contents
  output logic exec_done, // instruction retired, one cycle
  input wire logic [VIDX_W-1:0] obs_index, // register to observe
  output logic [VEC_W-1:0] obs_data // observed register, one cycle late
);

  typedef struct packed {
    sbva_state_e state;
    logic readout;
    logic [7:0] opcode;
    logic [VIDX_W-1:0] dst;
    logic [7:0] imm;
    logic [2:0] ftgt;
    logic swz_hi;
    logic fractint;
    logic uns;
    logic [2:0] shift;
    logic lo;
    logic rnd;
    logic [NCOND-1:0][COND_W-1:0] lane_condition_reg;
    logic [LANES-1:0][ACC_W-1:0] acc;
    logic tie_down;
    logic [15:0] illegal_cnt;
    logic done;
    logic [31:0] prdata;
  } sbva_core_s;

  sbva_core_s q;
  sbva_core_s next_q;

  // ------------------------------------------------------------------
  // lane functions
  // ------------------------------------------------------------------
  function automatic sbva_aop_e decode_aop(input logic [7:0] op);
    sbva_aop_e a;
    a = AOP_NONE;
    if (op == 8'h88) a = AOP_MIN;
    else if (op == 8'h89) a = AOP_MAX;
    else if (op == 8'h8a) a = AOP_ABS;
    else if (op == 8'h8b) a = AOP_NEG;
    else if (op == 8'h8c) a = AOP_ADD;
    else if (op == 8'h8d) a = AOP_SUB;
    else if (op == 8'h9a) a = AOP_ABS;
    else if (op == 8'h9c) a = AOP_ADD;
    else if (op == 8'h9d) a = AOP_SUB;
    else if (op == 8'ha8) a = AOP_MIN;
    else if (op == 8'ha9) a = AOP_MAX;
    else if (op == 8'hac) a = AOP_ADD;
    else if (op == 8'hb8) a = AOP_SUB;
    else if (op == 8'hb9) a = AOP_MIN;
    else if (op == 8'hbc) a = AOP_MAX;
    else if (op == 8'hbd) a = AOP_SUB;
    return a;
  endfunction : decode_aop

  // returns {sign flag, result byte}
  function automatic logic [8:0] alu_lane(input sbva_aop_e aop, input logic [7:0] a,
                                          input logic [7:0] b, input logic uns);
    logic signed [9:0] x;
    logic signed [9:0] y;
    logic signed [9:0] r;
    logic flag;
    x = uns ? {2'b00, a} : {{2{a[7]}}, a};
    y = uns ? {2'b00, b} : {{2{b[7]}}, b};
    case (aop)
      AOP_MIN: r = (x < y) ? x : y;
      AOP_MAX: r = (x > y) ? x : y;
      AOP_ABS: r = (x < 10'sh0) ? -x : x;
      AOP_NEG: r = -x;
      AOP_ADD: r = x + y;
      default: r = x - y;
    endcase
    flag = 1'b0;
    if (uns) begin
      if (r < 10'sh0) begin
        r = 10'sh0;
        flag = 1'b1;
      end
      if (r > B_UMAX) begin
        r = B_UMAX;
        flag = 1'b1;
      end
    end else begin
      flag = r < 10'sh0;
      if (r < B_SMIN) r = B_SMIN;
      if (r > B_SMAX) r = B_SMAX;
    end
    return {flag, r[7:0]};
  endfunction : alu_lane

  // returns {sign flag, median byte}
  function automatic logic [8:0] clip_lane(input logic [7:0] a, input logic [7:0] b,
                                           input logic [7:0] c);
    logic signed [7:0] v;
    logic signed [7:0] lo_end;
    logic signed [7:0] hi_end;
    logic flag;
    v = a;
    flag = 1'b0;
    if ($signed(b) < $signed(c)) begin
      lo_end = b;
      hi_end = c;
    end else begin
      lo_end = c;
      hi_end = b;
      flag = 1'b1;
    end
    if (v <= lo_end) begin
      v = lo_end;
      flag = 1'b1;
    end
    if (v >= hi_end) begin
      v = hi_end;
      flag = 1'b1;
    end
    return {flag, v};
  endfunction : clip_lane

  // ------------------------------------------------------------------
  // register file and readout lanes
  // ------------------------------------------------------------------
  logic [4*VEC_W-1:0] rd_bus;
  logic [LANES-1:0][7:0] s1v;
  logic [LANES-1:0][7:0] s2v;
  logic [LANES-1:0][7:0] s3v;
  logic mem_we;
  logic [LANES-1:0][7:0] result;
  logic [LANES-1:0][ACC_W-1:0] acc_rounded;
  logic [LANES-1:0][7:0] ro_byte;

  sbva_vreg_mem #(
    .DEPTH(VREGS),
    .WIDTH(VEC_W),
    .AW(VIDX_W),
    .NRD(4)
  ) u_vregs (
    .pclk(pclk),
    .presetn(presetn),
    .rd_addr({obs_index, third_source_index, second_source_index, first_source_index}),
    .rd_data(rd_bus),
    .we(mem_we),
    .wr_addr(q.dst),
    .wr_data(result)
  );

  assign s1v = rd_bus[0*VEC_W +: VEC_W];
  assign s2v = rd_bus[1*VEC_W +: VEC_W];
  assign s3v = rd_bus[2*VEC_W +: VEC_W];
  assign obs_data = rd_bus[3*VEC_W +: VEC_W];

  for (genvar g = 0; g < LANES; g++) begin : g_ro
    sbva_readout_lane u_ro (
      .acc_in(q.acc[g]),
      .fractint(q.fractint),
      .is_unsigned(q.uns),
      .shift(q.shift),
      .hilo_lo(q.lo),
      .rnd(q.rnd),
      .tie_down(q.tie_down),
      .acc_out(acc_rounded[g]),
      .byte_out(ro_byte[g])
    );
  end

  // ------------------------------------------------------------------
  // execute
  // ------------------------------------------------------------------
  sbva_aop_e aop;
  logic [LANES-1:0] sign_flag;
  logic [LANES-1:0] zero_flag;
  logic wr_vec;
  logic wr_flags;
  logic illegal;

  always_comb begin
    logic [8:0] lr;
    logic [7:0] opnd;
    logic [3:0] comp;
    logic src;
    lr = '0;
    opnd = '0;
    comp = '0;
    src = 1'b0;
    aop = decode_aop(q.opcode);
    result = '0;
    sign_flag = '0;
    wr_vec = 1'b1;
    wr_flags = 1'b0;
    illegal = 1'b0;
    if (q.readout) begin
      result = ro_byte;
    end else if (q.opcode == OP_MOV) begin
      result = s1v;
      wr_flags = 1'b1;
    end else if (q.opcode == OP_MOVI) begin
      result = {LANES{q.imm}};
      sign_flag = {LANES{q.imm[7]}};
      wr_flags = 1'b1;
    end else if (q.opcode == OP_MOVVC) begin
      result = q.lane_condition_reg;
    end else if (q.opcode == OP_SWZ) begin
      for (int i = 0; i < LANES; i++) begin
        comp = q.swz_hi ? s3v[i][7:4] : s3v[i][3:0];
        src = q.swz_hi ? s3v[i][0] : s3v[i][4];
        result[i] = src ? s2v[comp] : s1v[comp];
      end
    end else if (q.opcode == CLIP_OPCODE) begin
      for (int i = 0; i < LANES; i++) begin
        lr = clip_lane(s1v[i], s2v[i], s3v[i]);
        result[i] = lr[7:0];
        sign_flag[i] = lr[8];
      end
      wr_flags = 1'b1;
    end else if (aop != AOP_NONE) begin
      for (int i = 0; i < LANES; i++) begin
        opnd = q.opcode[OPB_IMM] ? q.imm : s2v[i];
        lr = alu_lane(aop, s1v[i], opnd, q.opcode[OPB_UNS]);
        result[i] = lr[7:0];
        sign_flag[i] = lr[8];
      end
      wr_flags = 1'b1;
    end else begin
      wr_vec = 1'b0;
      illegal = 1'b1;
    end
    for (int i = 0; i < LANES; i++) begin
      zero_flag[i] = result[i] == 8'h00;
    end
  end

  assign mem_we = (q.state == ST_EXEC) && wr_vec;

  // ------------------------------------------------------------------
  // apb read mux
  // ------------------------------------------------------------------
  function automatic logic [32:0] reg_read(input logic [11:0] addr, input sbva_core_s s);
    logic [32:0] r;
    r = '0;
    if (addr == REG_CFG) begin
      r[CFG_TIE_BIT] = s.tie_down;
    end else if (addr == REG_STATUS) begin
      r = {1'b0, s.illegal_cnt, 15'h0000, s.state == ST_EXEC};
    end else if (addr >= REG_COND0 && addr <= REG_COND3 && addr[1:0] == 2'b00) begin
      // sign flags low half, zero flags high half
      r = {1'b0, s.lane_condition_reg[addr[3:2]]};
    end else begin
      r = {1'b1, 32'h00000000};
    end
    return r;
  endfunction : reg_read

  logic [32:0] rd_word;
  assign rd_word = reg_read(paddr, q);

  // ------------------------------------------------------------------
  // state update
  // ------------------------------------------------------------------
  always_comb begin
    next_q = q;
    next_q.done = 1'b0;
    if (psel && !penable) begin
      next_q.prdata = rd_word[31:0];
    end
    if (psel && penable && pwrite && paddr == REG_CFG) begin
      next_q.tie_down = pwdata[CFG_TIE_BIT];
    end
    case (q.state)
      ST_IDLE: begin
        if (issue_valid) begin
          next_q.state = ST_EXEC;
          next_q.readout = issue_readout;
          next_q.opcode = opcode;
          next_q.dst = dest_index;
          next_q.imm = byte_immediate;
          next_q.ftgt = flag_target_index;
          next_q.swz_hi = selector_nibble_order;
          next_q.fractint = readout_int;
          next_q.uns = readout_unsigned;
          next_q.shift = readout_shift;
          next_q.lo = readout_lo;
          next_q.rnd = readout_rnd;
        end else if (acc_load_valid) begin
          next_q.acc = acc_load_data;
        end
      end
      ST_EXEC: begin
        next_q.state = ST_IDLE;
        next_q.done = 1'b1;
        if (q.readout) begin
          next_q.acc = acc_rounded;
        end
        if (wr_flags && q.ftgt < 3'(NCOND)) begin
          next_q.lane_condition_reg[q.ftgt[1:0]] = {zero_flag, sign_flag};
        end
        if (illegal) begin
          next_q.illegal_cnt = q.illegal_cnt + 16'h0001;
        end
      end
      default: begin
        next_q.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.tie_down <= CFG_TIE_RESET;
    end else begin
      q <= next_q;
    end
  end

  assign prdata = q.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && rd_word[32];
  assign issue_ready = q.state == ST_IDLE;
  assign exec_done = q.done;
  assign wide_accumulator = q.acc;

endmodule : sbva_core

// *** verification/sbva_core_assertions.sv ***
// port assertions of the byte vector datapath
module sbva_core_chk
  import sbva_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic [11:0] paddr, // address
  input wire logic pslverr, // error
  input wire logic issue_valid, // offer
  input wire logic issue_ready, // accept
  input wire logic exec_done, // retire
  input wire logic acc_load_valid, // load
  input wire logic [LANES*ACC_W-1:0] acc_load_data, // load value
  input wire logic [LANES*ACC_W-1:0] wide_accumulator // accumulator
);
  wire logic mapped = paddr inside {12'h000, 12'h004, 12'h010, 12'h014, 12'h018, 12'h01c};
  wire logic load = acc_load_valid && issue_ready && !issue_valid;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_take;
    issue_valid && issue_ready;
  endsequence
  sequence s_retire;
    !issue_ready ##1 (exec_done && issue_ready);
  endsequence
  a_take_retire: assert property (s_take |=> s_retire)
    else $error("issue not retired");
  a_one_pulse: assert property (exec_done |=> !exec_done)
    else $error("retire pulse too long");
  a_done_busy: assert property (exec_done |-> issue_ready && !$past(issue_ready))
    else $error("retire not after busy cycle");
  a_done_cause: assert property (exec_done |-> $past(issue_valid && issue_ready, 2))
    else $error("retire without issue");
  a_err_map: assert property (psel && penable |-> pslverr == !mapped)
    else $error("wrong error response");
  a_err_idle: assert property (!(psel && penable) |-> !pslverr)
    else $error("error outside access");
  a_acc_load: assert property (load |=> wide_accumulator == $past(acc_load_data))
    else $error("accumulator not loaded");
  a_acc_hold: assert property ($changed(wide_accumulator) |-> exec_done || $past(load))
    else $error("accumulator changed alone");
endmodule : sbva_core_chk

bind sbva_core sbva_core_chk sbva_core_chk_i (.*);

// *** verification/sbva_issuer.sv ***
// issuing side model: offers one instruction and holds it until taken
module sbva_issuer
  import sbva_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic issue_ready, // accept
  output logic issue_valid, // offer
  output logic issue_readout, // readout form
  output logic [7:0] opcode, // opcode
  output logic [VIDX_W-1:0] dest_index, // destination
  output logic [VIDX_W-1:0] first_source_index, // source one
  output logic [VIDX_W-1:0] second_source_index, // source two
  output logic [VIDX_W-1:0] third_source_index, // source three
  output logic [7:0] byte_immediate, // immediate
  output logic [2:0] flag_target_index, // flag target
  output logic selector_nibble_order, // swizzle decode
  output logic readout_int, // integer mode
  output logic readout_unsigned, // unsigned
  output logic [2:0] readout_shift, // extra shift
  output logic readout_lo, // low byte
  output logic readout_rnd // rounding
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {issue_valid, issue_readout, opcode, byte_immediate, flag_target_index} = '0;
  initial {dest_index, first_source_index, second_source_index, third_source_index} = '0;
  initial {selector_nibble_order, readout_int, readout_unsigned, readout_shift} = '0;
  initial {readout_lo, readout_rnd} = '0;
  task automatic send(input logic rdo, input logic [7:0] op, input logic [4:0] d, a, b, c,
    input logic [7:0] imm, input logic [2:0] ft, input logic [7:0] md);
    int n;
    issue_valid <= 1'b1;
    issue_readout <= rdo;
    {opcode, byte_immediate, flag_target_index} <= {op, imm, ft};
    {dest_index, first_source_index, second_source_index, third_source_index} <= {d, a, b, c};
    {selector_nibble_order, readout_int, readout_unsigned} <= md[7:5];
    {readout_shift, readout_lo, readout_rnd} <= md[4:0];
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (!issue_ready && n < 50);
    issue_valid <= 1'b0;
    // released fields turn over
    {opcode, byte_immediate, dest_index} <= ~{op, imm, d};
    @(posedge pclk);
  endtask : send
endmodule : sbva_issuer

// *** verification/tb_sbva_core.sv ***
// self-checking bench of the byte vector datapath
module tb_sbva_core
  import sbva_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------
  // signals
  // ----------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, acc_load_valid = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, issue_ready, exec_done, issue_valid, issue_readout;
  logic selector_nibble_order, readout_int, readout_unsigned, readout_lo, readout_rnd;
  logic [LANES*ACC_W-1:0] acc_load_data = '0, wide_accumulator;
  logic [VIDX_W-1:0] obs_index = '0, dest_index, first_source_index;
  logic [VIDX_W-1:0] second_source_index, third_source_index;
  logic [VEC_W-1:0] obs_data;
  logic [7:0] opcode, byte_immediate;
  logic [2:0] flag_target_index, readout_shift;
  int fails = 0, checks_done = 0;
  logic [7:0] alu_op [18] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h9a, 8'h9c, 8'h9d,
    8'ha8, 8'ha9, 8'hac, 8'hb8, 8'hb9, 8'hbc, 8'hbd, OP_CLIP_DEFAULT, OP_CLIP_DEFAULT};
  logic [7:0] alu_res [18] = '{8'h20, 8'h70, 8'h70, 8'h90, 8'h7f, 8'h50, 8'h70, 8'h90, 8'h50,
    8'h90, 8'h70, 8'h00, 8'h00, 8'h70, 8'h90, 8'h00, 8'h30, 8'h20};
  // sign flag, zero flag
  logic [1:0] alu_flg [18] = '{2'b00, 2'b00, 2'b00, 2'b10, 2'b00, 2'b00, 2'b00, 2'b00, 2'b00,
    2'b10, 2'b00, 2'b01, 2'b11, 2'b00, 2'b00, 2'b11, 2'b10, 2'b10};
  sbva_core sbva_core_i (.*);
  sbva_issuer sbva_issuer_i (.*);
  always #2 pclk = ~pclk;
  // ----------------
  // tasks
  // ----------------
  task automatic chk(input string nm, input logic [LANES*ACC_W-1:0] e, g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, x,
    input logic xe);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (!pready);
    if (!w) chk($sformatf("reg %h", a), x, prdata);
    chk("pslverr", xe, pslverr);
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask : apb
  task automatic op(input logic [7:0] o, input int d, a, b, c, input logic [7:0] im,
    input logic [2:0] ft, input logic nib);
    sbva_issuer_i.send(1'b0, o, d[4:0], a[4:0], b[4:0], c[4:0], im, ft, {nib, 7'h00});
    @(posedge pclk);
    chk("exec_done", 1'b1, exec_done);
  endtask : op
  task automatic see(input int i, input logic [127:0] x);
    obs_index <= i[4:0];
    repeat (2) @(posedge pclk);
    chk($sformatf("vector %0d", i), x, obs_data);
  endtask : see
  task automatic ro(input logic ld, input logic [27:0] a, input logic [7:0] md, x,
    input logic [27:0] xa);
    if (ld) begin
      {acc_load_valid, acc_load_data} <= {1'b1, {16{a}}};
      @(posedge pclk);
      acc_load_valid <= 1'b0;
    end
    sbva_issuer_i.send(1'b1, 8'h00, 5'd13, 5'd0, 5'd0, 5'd0, 8'h00, 3'h7, md);
    @(posedge pclk);
    chk("exec_done", 1'b1, exec_done);
    chk("accumulator", {16{xa}}, wide_accumulator);
    see(13, {16{x}});
  endtask : ro
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  // ----------------
  // sequence
  // ----------------
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h000, '0, 32'h0, 1'b0);
    apb(1'b0, 12'h040, '0, 32'h0, 1'b1);
    apb(1'b1, 12'h044, 32'h1, '0, 1'b1);
    $display("test registers done");
    op(OP_MOVI, 1, 0, 0, 0, 8'h80, 3'h3, 1'b0);
    see(1, {16{8'h80}});
    apb(1'b0, 12'h01c, '0, 32'h0000ffff, 1'b0);
    op(OP_MOVI, 3, 0, 0, 0, 8'h00, 3'h4, 1'b0);
    see(3, '0);
    apb(1'b0, 12'h01c, '0, 32'h0000ffff, 1'b0);
    op(OP_MOV, 2, 1, 0, 0, 8'h00, 3'h3, 1'b0);
    see(2, {16{8'h80}});
    apb(1'b0, 12'h01c, '0, 32'h0, 1'b0);
    op(OP_MOV, 4, 3, 0, 0, 8'h00, 3'h1, 1'b0);
    apb(1'b0, 12'h014, '0, 32'hffff0000, 1'b0);
    $display("test moves done");
    op(OP_MOVI, 5, 0, 0, 0, 8'h70, 3'h7, 1'b0);
    op(OP_MOVI, 6, 0, 0, 0, 8'h20, 3'h7, 1'b0);
    op(OP_MOVI, 9, 0, 0, 0, 8'h30, 3'h7, 1'b0);
    op(OP_MOVI, 10, 0, 0, 0, 8'h10, 3'h7, 1'b0);
    op(OP_MOVI, 8, 0, 0, 0, 8'h94, 3'h7, 1'b0);
    for (int i = 0; i < 18; i++) begin
      op(alu_op[i], 7, 5, 6, (i == 17) ? 10 : 9, 8'h90, 3'h2, 1'b0);
      see(7, {16{alu_res[i]}});
      apb(1'b0, 12'h018, '0, {{16{alu_flg[i][0]}}, {16{alu_flg[i][1]}}}, 1'b0);
    end
    $display("test arithmetic done");
    op(OP_MOVVC, 12, 0, 0, 0, 8'h00, 3'h7, 1'b0);
    see(12, {32'h0, 32'h0000ffff, 32'hffff0000, 32'h0});
    op(OP_SWZ, 11, 12, 5, 8, 8'h00, 3'h7, 1'b0);
    see(11, {16{8'h70}});
    op(OP_SWZ, 11, 12, 5, 8, 8'h00, 3'h7, 1'b1);
    see(11, {16{8'hff}});
    op(8'h80, 14, 0, 0, 0, 8'h00, 3'h0, 1'b0);
    apb(1'b0, 12'h004, '0, 32'h00010000, 1'b0);
    apb(1'b0, 12'h010, '0, 32'h0, 1'b0);
    $display("test swizzle done");
    // low byte rounded first, then high byte
    ro(1'b1, 28'h0123480, 8'h43, 8'h35, 28'h0123500);
    ro(1'b0, 28'h0, 8'h40, 8'h12, 28'h0123500);
    ro(1'b1, 28'h0123480, 8'h41, 8'h12, 28'h012b480);
    ro(1'b1, 28'h0800000, 8'h42, 8'hff, 28'h0800000);
    ro(1'b1, 28'h1000000, 8'h60, 8'hff, 28'h1000000);
    ro(1'b1, 28'h7ffff80, 8'h43, 8'h00, 28'h8000000);
    ro(1'b1, 28'h0000010, 8'h2e, 8'h80, 28'h0000010);
    ro(1'b1, 28'h0000100, 8'h12, 8'h08, 28'h0000100);
    apb(1'b1, 12'h000, 32'h1, '0, 1'b0);
    apb(1'b0, 12'h000, '0, 32'h1, 1'b0);
    ro(1'b1, 28'h0123480, 8'h43, 8'h34, 28'h01234ff);
    $display("test readout done");
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    complete_run();
  end
endmodule : tb_sbva_core
